// file: hw/eipc_map.svh
// Register offsets, field positions, reset values and timing counts
//
// Contract
// - Linear resolution means encoder units per count.
// - Linear electrical distance counts units per cycle.
// - Direction 0 counts normal, 1 reversed.
// - Index spacing: counts rotary, units linear.
// - Analog shift n gives 2^(n+2) counts/line.
// - Index capture stores axis position, read-only.
// - Reading captured index clears status bits 0,3.
// - Raw velocity signed 32-bit, 0.1 counts/s.
// - Control bit 0 captures on index rise.
// - Control bit 1 captures on index fall.
// - Control bit 2 holds capture until read.
// - Control bit 5 picks home capture edge.
// - Control bits 3 and 4 do nothing.
// - Status bit 0 set on capture, read clears.
// - Status bit 3 flags transition while stored.
`ifndef EIPC_MAP_SVH
`define EIPC_MAP_SVH

// Parameter identifiers on the parameter port
`define EIPC_ADDR_LIN_RES        9'h063
`define EIPC_ADDR_LIN_ELEC_LEN   9'h064
`define EIPC_ADDR_FB_DIR         9'h065
`define EIPC_ADDR_IDX_SPACING    9'h066
`define EIPC_ADDR_INTERP_SHIFT   9'h067
`define EIPC_ADDR_CAP_INDEX      9'h068
`define EIPC_ADDR_RAW_VEL        9'h069
`define EIPC_ADDR_CAP_CTRL       9'h06c
`define EIPC_ADDR_CAP_STATUS     9'h06d
`define EIPC_ADDR_CAP_HOME       9'h10a

// Capture control fields
`define EIPC_CTL_IDX_RISE        0
`define EIPC_CTL_IDX_FALL        1
`define EIPC_CTL_IDX_HOLD        2
`define EIPC_CTL_HOME_FALL       5
`define EIPC_CTL_HOME_HOLD       6
`define EIPC_CTL_WRITE_MASK      16'h0067

// Capture status fields
`define EIPC_STS_IDX_CAP         0
`define EIPC_STS_IDX_OVR         3
`define EIPC_STS_HOME_CAP        4
`define EIPC_STS_HOME_OVR        7

// Reset values
`define EIPC_RST_LIN_RES         16'h0001
`define EIPC_RST_LIN_ELEC_LEN    32'h0000_0000
`define EIPC_RST_FB_DIR          16'h0000
`define EIPC_RST_IDX_SPACING     32'h0000_0000
`define EIPC_RST_INTERP_SHIFT    16'h0000
`define EIPC_RST_CAP_CTRL        16'h0000

// Interpolation limits and velocity timing
`define EIPC_SHIFT_MAX           5'd14
`define EIPC_PHASE_BITS          5'd16
`define EIPC_CLK_MHZ             250
`define EIPC_VEL_PERIOD_US       1000
`define EIPC_VEL_CYCLES          (`EIPC_VEL_PERIOD_US * `EIPC_CLK_MHZ)
`define EIPC_VEL_SCALE           (10 * 1000000 / `EIPC_VEL_PERIOD_US)

`endif

// file: hw/eipc_pkg.sv
// Types shared by the index and home position capture block
package eipc_pkg;
	typedef logic [8:0]         eipc_addr_t;
	typedef logic [31:0]        eipc_word_t;
	typedef logic signed [31:0] eipc_pos_t;
	typedef enum logic {EIPC_FB_QUAD, EIPC_FB_ANALOG} eipc_fb_mode_t;
endpackage

// file: hw/eipc_capture.sv
// One position capture channel with hold mode and overrun flag
`timescale 1ns/1ps
`include "eipc_map.svh"
module eipc_capture
(
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             event_pulse,
	input  wire eipc_pkg::eipc_pos_t position,
	input  wire logic             hold,
	input  wire logic             clear,
	output eipc_pkg::eipc_pos_t   value,
	output logic                  captured,
	output logic                  overrun
);
	import eipc_pkg::*;

	// A stored value is protected only while hold is set and unread
	wire   blocked   = captured && hold && !clear;
	wire   take      = event_pulse && !blocked;
	wire   collide   = event_pulse && captured && !clear;
	wire   next_cap  = event_pulse || (captured && !clear);
	wire   next_ovr  = collide || (overrun && !clear);

	// Set wins over a read clear in the same cycle
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			value    <= 32'sh0000_0000;
			captured <= 1'b0;
			overrun  <= 1'b0;
		end
		else
		begin
			if (take)
				value <= position;
			captured <= next_cap;
			overrun  <= next_ovr;
		end
	end
endmodule

// file: hw/eipc_top.sv
// Encoder feedback scaling and index/home position capture block
`timescale 1ns/1ps
`include "eipc_map.svh"
module eipc_top
#(
	parameter int unsigned VEL_CYCLES = `EIPC_VEL_CYCLES
)
(
	input  wire logic                 clk,
	input  wire logic                 reset_n,
	input  wire logic                 enc_a,
	input  wire logic                 enc_b,
	input  wire logic [15:0]          interp_phase,
	input  wire eipc_pkg::eipc_fb_mode_t fb_mode,
	input  wire logic                 motor_is_linear,
	input  wire logic                 index_in,
	input  wire logic                 home_active,
	input  wire eipc_pkg::eipc_addr_t param_addr,
	input  wire logic                 param_wr,
	input  wire logic                 param_rd,
	input  wire eipc_pkg::eipc_word_t param_wdata,
	output eipc_pkg::eipc_word_t      param_rdata,
	output logic                      param_ack,
	output logic                      param_err,
	output eipc_pkg::eipc_pos_t       axis_position,
	output eipc_pkg::eipc_pos_t       elec_position,
	output logic                      phasing_reversed,
	output logic                      index_spacing_fault,
	output logic                      index_seen
);
	import eipc_pkg::*;

	// Quadrature step from previous and current A/B state
	function automatic logic signed [1:0] quad_step(input logic [1:0] p,
		input logic [1:0] c);
		logic signed [1:0] s;
		s = 2'sb00;
		case ({p, c})
			4'b0001, 4'b0111, 4'b1110, 4'b1000: s = 2'sb01;
			4'b0010, 4'b1011, 4'b1101, 4'b0100: s = -2'sb01;
			default: s = 2'sb00;
		endcase
		return s;
	endfunction

	// Travel in counts, or in encoder units for a linear motor
	function automatic eipc_pos_t to_travel(input eipc_pos_t d,
		input logic [15:0] res, input logic lin);
		logic signed [47:0] p;
		p = 48'(d) * 48'(signed'({16'h0000, res}));
		return lin ? 32'(p) : d;
	endfunction

	// Parameter storage
	logic [15:0] lin_res;
	eipc_word_t  lin_elec_len;
	logic [15:0] fb_dir;
	eipc_word_t  idx_spacing;
	logic [15:0] interp_shift;
	logic [15:0] cap_ctrl;
	eipc_pos_t   raw_vel;

	// Parameter decode
	wire hit_res   = param_addr == `EIPC_ADDR_LIN_RES;
	wire hit_len   = param_addr == `EIPC_ADDR_LIN_ELEC_LEN;
	wire hit_dir   = param_addr == `EIPC_ADDR_FB_DIR;
	wire hit_spc   = param_addr == `EIPC_ADDR_IDX_SPACING;
	wire hit_shf   = param_addr == `EIPC_ADDR_INTERP_SHIFT;
	wire hit_cidx  = param_addr == `EIPC_ADDR_CAP_INDEX;
	wire hit_vel   = param_addr == `EIPC_ADDR_RAW_VEL;
	wire hit_ctl   = param_addr == `EIPC_ADDR_CAP_CTRL;
	wire hit_sts   = param_addr == `EIPC_ADDR_CAP_STATUS;
	wire hit_chome = param_addr == `EIPC_ADDR_CAP_HOME;
	wire hit_rw    = hit_res || hit_len || hit_dir || hit_spc || hit_shf
		|| hit_ctl;
	wire hit_any   = hit_rw || hit_cidx || hit_vel || hit_sts || hit_chome;

	// Parameter writes; read-only identifiers ignore writes
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			lin_res      <= `EIPC_RST_LIN_RES;
			lin_elec_len <= `EIPC_RST_LIN_ELEC_LEN;
			fb_dir       <= `EIPC_RST_FB_DIR;
			idx_spacing  <= `EIPC_RST_IDX_SPACING;
			interp_shift <= `EIPC_RST_INTERP_SHIFT;
			cap_ctrl     <= `EIPC_RST_CAP_CTRL;
		end
		else if (param_wr)
		begin
			if (hit_res)
				lin_res <= param_wdata[15:0];
			if (hit_len)
				lin_elec_len <= param_wdata;
			if (hit_dir)
				fb_dir <= param_wdata[15:0];
			if (hit_spc)
				idx_spacing <= param_wdata;
			if (hit_shf)
				interp_shift <= param_wdata[15:0];
			if (hit_ctl)
				cap_ctrl <= param_wdata[15:0] & `EIPC_CTL_WRITE_MASK;
		end
	end

	// Feedback direction and analog interpolation setup
	wire         reverse   = fb_dir[0];
	wire         shift_neg = interp_shift[15];
	wire         shift_big = interp_shift[14:0] > 15'(`EIPC_SHIFT_MAX);
	wire [4:0]   shift_n   = shift_neg ? 5'd0 :
		(shift_big ? `EIPC_SHIFT_MAX : interp_shift[4:0]);

	// Encoder input history
	logic [1:0]  ab_prev;
	eipc_pos_t   qcount;
	wire  [1:0]  ab_now  = {enc_a, enc_b};
	wire  signed [1:0] step = quad_step(ab_prev, ab_now);

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ab_prev <= 2'b00;
			qcount  <= 32'sh0000_0000;
		end
		else
		begin
			ab_prev <= ab_now;
			qcount  <= qcount + 32'(step);
		end
	end

	// Analog mode: four counts per line, widened by n fraction bits
	wire [31:0]  frac      = {16'h0000, interp_phase}
		>> (`EIPC_PHASE_BITS - shift_n);
	wire eipc_pos_t analog_pos = (qcount <<< shift_n) + signed'(frac);
	wire eipc_pos_t raw_pos    = (fb_mode == EIPC_FB_ANALOG) ?
		analog_pos : qcount;
	wire eipc_pos_t next_axis_position = reverse ? -raw_pos : raw_pos;
	wire eipc_pos_t axis_delta = next_axis_position - axis_position;

	// Axis position follows the scaled, direction-corrected feedback
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			axis_position    <= 32'sh0000_0000;
			phasing_reversed <= 1'b0;
		end
		else
		begin
			axis_position    <= next_axis_position;
			phasing_reversed <= reverse;
		end
	end

	// Electrical position within one cycle for linear motors
	wire eipc_pos_t unit_step  = to_travel(axis_delta, lin_res, 1'b1);
	wire eipc_pos_t elec_sum   = elec_position + unit_step;
	wire eipc_pos_t elec_len   = signed'(lin_elec_len);
	wire         elec_wrap_hi = elec_sum >= elec_len;
	wire         elec_wrap_lo = elec_sum < 32'sh0000_0000;
	wire eipc_pos_t next_elec_position =
		(!motor_is_linear || elec_len <= 32'sh0000_0000) ? 32'sh0000_0000 :
		elec_wrap_hi ? elec_sum - elec_len :
		elec_wrap_lo ? elec_sum + elec_len : elec_sum;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			elec_position <= 32'sh0000_0000;
		else
			elec_position <= next_elec_position;
	end

	// Velocity sample period divider
	logic [31:0] vel_cnt;
	eipc_pos_t   vel_base;
	wire         vel_tick = vel_cnt == 32'(VEL_CYCLES - 1);
	wire eipc_pos_t vel_diff = axis_position - vel_base;
	wire signed [63:0] vel_prod = 64'(vel_diff)
		* 64'(signed'(32'(`EIPC_VEL_SCALE)));

	// Unfiltered velocity sampled each period, 0.1 count/s units
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			vel_cnt  <= 32'h0000_0000;
			vel_base <= 32'sh0000_0000;
			raw_vel  <= 32'sh0000_0000;
		end
		else
		begin
			vel_cnt <= vel_tick ? 32'h0000_0000 : vel_cnt + 32'h0000_0001;
			if (vel_tick)
			begin
				vel_base <= axis_position;
				raw_vel  <= 32'(vel_prod);
			end
		end
	end

	// Index and home edge detection
	logic index_prev;
	logic home_prev;
	wire  idx_rise  = index_in && !index_prev;
	wire  idx_fall  = !index_in && index_prev;
	wire  idx_event = (idx_rise && cap_ctrl[`EIPC_CTL_IDX_RISE])
		|| (idx_fall && cap_ctrl[`EIPC_CTL_IDX_FALL]);
	wire  home_on   = home_active && !home_prev;
	wire  home_off  = !home_active && home_prev;
	wire  home_event = cap_ctrl[`EIPC_CTL_HOME_FALL] ? home_off : home_on;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			index_prev <= 1'b0;
			home_prev  <= 1'b0;
		end
		else
		begin
			index_prev <= index_in;
			home_prev  <= home_active;
		end
	end

	// Reads of the captured positions release their status flags
	wire clr_index = param_rd && hit_cidx;
	wire clr_home  = param_rd && hit_chome;

	eipc_pos_t idx_value;
	logic      idx_cap;
	logic      idx_ovr;
	eipc_pos_t home_value;
	logic      home_cap;
	logic      home_ovr;

	eipc_capture u_index_cap
	(
		.clk         (clk),
		.reset_n     (reset_n),
		.event_pulse (idx_event),
		.position    (axis_position),
		.hold        (cap_ctrl[`EIPC_CTL_IDX_HOLD]),
		.clear       (clr_index),
		.value       (idx_value),
		.captured    (idx_cap),
		.overrun     (idx_ovr)
	);

	eipc_capture u_home_cap
	(
		.clk         (clk),
		.reset_n     (reset_n),
		.event_pulse (home_event),
		.position    (axis_position),
		.hold        (cap_ctrl[`EIPC_CTL_HOME_HOLD]),
		.clear       (clr_home),
		.value       (home_value),
		.captured    (home_cap),
		.overrun     (home_ovr)
	);

	// Index spacing check: travel between accepted index edges
	eipc_pos_t travel;
	wire eipc_pos_t travel_step = to_travel(axis_delta, lin_res,
		motor_is_linear);
	wire eipc_pos_t travel_abs  = travel[31] ? -travel : travel;
	wire         spacing_bad = idx_spacing != 32'h0000_0000
		&& travel_abs != signed'(idx_spacing);

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			travel              <= 32'sh0000_0000;
			index_seen          <= 1'b0;
			index_spacing_fault <= 1'b0;
		end
		else if (idx_event)
		begin
			travel     <= travel_step;
			index_seen <= 1'b1;
			index_spacing_fault <= index_seen && spacing_bad;
		end
		else
			travel <= travel + travel_step;
	end

	// Status word and read selection
	wire [15:0] cap_status = {8'h00, home_ovr, 2'b00, home_cap,
		idx_ovr, 2'b00, idx_cap};
	wire eipc_word_t read_value =
		hit_res   ? {16'h0000, lin_res} :
		hit_len   ? lin_elec_len :
		hit_dir   ? {16'h0000, fb_dir} :
		hit_spc   ? idx_spacing :
		hit_shf   ? {16'h0000, interp_shift} :
		hit_cidx  ? idx_value :
		hit_vel   ? raw_vel :
		hit_ctl   ? {16'h0000, cap_ctrl} :
		hit_sts   ? {16'h0000, cap_status} :
		hit_chome ? home_value : 32'h0000_0000;
	wire bad_access = (param_rd && !hit_any) || (param_wr && !hit_rw);

	// Parameter answer one cycle after the strobe
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			param_rdata <= 32'h0000_0000;
			param_ack   <= 1'b0;
			param_err   <= 1'b0;
		end
		else
		begin
			param_ack <= param_rd || param_wr;
			param_err <= bad_access;
			if (param_rd)
				param_rdata <= read_value;
		end
	end
endmodule

// file: testbench/eipc_assertions.sv
// Port checker for the parameter port, direction output and index seen flag
`timescale 1ns/1ps
module eipc_assertions
#(
	parameter int unsigned VEL_CYCLES = 100
)
(
	input wire logic                 clk,
	input wire logic                 reset_n,
	input wire logic                 index_in,
	input wire eipc_pkg::eipc_addr_t param_addr,
	input wire logic                 param_wr,
	input wire logic                 param_rd,
	input wire eipc_pkg::eipc_word_t param_wdata,
	input wire eipc_pkg::eipc_word_t param_rdata,
	input wire logic                 param_ack,
	input wire logic                 param_err,
	input wire logic                 phasing_reversed,
	input wire logic                 index_seen
);
	import eipc_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Strobe and address decode helpers
	wire logic strobe = param_rd | param_wr;
	wire logic mapped = param_addr inside {9'h063, 9'h064, 9'h065,
		9'h066, 9'h067, 9'h068, 9'h069, 9'h06c, 9'h06d, 9'h10a};
	property p_ack_after; strobe |=> param_ack; endproperty
	property p_ack_cause; param_ack |-> $past(strobe); endproperty
	property p_err_ack; param_err |-> param_ack; endproperty
	property p_ro_wr; param_wr && param_addr == 9'h068 |=> param_err;
	endproperty
	property p_unmapped; param_rd && !mapped |=>
		param_err && param_rdata == 32'h0; endproperty
	property p_rd_hold; !param_rd |=> $stable(param_rdata); endproperty
	property p_ctl_rsvd; param_rd && param_addr == 9'h06c |=>
		param_rdata[4:3] == 2'h0 && param_rdata[31:7] == 25'h0; endproperty
	property p_dir; param_wr && param_addr == 9'h065 |-> ##2
		phasing_reversed == $past(param_wdata[0], 2); endproperty
	property p_seen; $rose(index_seen) |->
		$past(index_in) != $past(index_in, 2); endproperty
	property p_seen_hold; index_seen |=> index_seen; endproperty
	a_ack_after: assert property (p_ack_after) else $error("no ack");
	a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
	a_err_ack: assert property (p_err_ack) else $error("err alone");
	a_ro_wr: assert property (p_ro_wr) else $error("ro write");
	a_unmapped: assert property (p_unmapped) else $error("unmapped");
	a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
	a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("rsvd");
	a_dir: assert property (p_dir) else $error("direction");
	a_seen: assert property (p_seen) else $error("seen w/o edge");
	a_seen_hold: assert property (p_seen_hold) else $error("seen drop");
	c_idx_rd: cover property (param_rd && param_addr == 9'h068 ##1 param_ack);
	c_err: cover property (param_err);
	c_seen: cover property ($rose(index_seen));
endmodule
bind eipc_top eipc_assertions #(.VEL_CYCLES(VEL_CYCLES)) chk_u (
	.clk(clk), .reset_n(reset_n), .index_in(index_in),
	.param_addr(param_addr), .param_wr(param_wr), .param_rd(param_rd),
	.param_wdata(param_wdata), .param_rdata(param_rdata),
	.param_ack(param_ack), .param_err(param_err),
	.phasing_reversed(phasing_reversed), .index_seen(index_seen));

// file: testbench/eipc_enc_model.sv
// Encoder stand-in: quadrature lines, index channel and home switch
`timescale 1ns/1ps
module eipc_enc_model
(
	input  wire logic clk,
	output logic      enc_a,
	output logic      enc_b,
	output logic      index_in,
	output logic      home_active
);
	logic [1:0] step_q = 2'h0;
	// B leads A when moving forward, so each step counts up
	assign enc_a = step_q[1];
	assign enc_b = step_q[1] ^ step_q[0];
	initial
	begin
		index_in = 1'b0;
		home_active = 1'b0;
	end
	// One count per transition, two clocks apart
	task automatic move(input int n);
		repeat (n)
		begin
			@(posedge clk);
			#1 step_q = step_q + 2'h1;
			@(posedge clk);
		end
		// Let the position register take the last count
		@(posedge clk);
		#1;
	endtask
	task automatic set_index(input logic v);
		@(posedge clk);
		#1 index_in = v;
		repeat (3) @(posedge clk);
	endtask
	task automatic set_home(input logic v);
		@(posedge clk);
		#1 home_active = v;
		repeat (3) @(posedge clk);
	endtask
endmodule

// file: testbench/tb.sv
// Self-checking bench for the index and home capture block
`timescale 1ns/1ps
module tb;
	import eipc_pkg::*;
	logic          clk, reset_n, enc_a, enc_b, index_in, home_active;
	logic          param_wr, param_rd, param_ack, param_err;
	logic          phasing_reversed, index_spacing_fault, index_seen;
	logic          motor_is_linear;
	logic [15:0]   interp_phase;
	eipc_fb_mode_t fb_mode;
	eipc_addr_t    param_addr;
	eipc_word_t    param_wdata, param_rdata, rd_data;
	eipc_pos_t     axis_position, elec_position;
	int            miscompares = 0;
	int            compares = 0;
	eipc_addr_t    rst_a [6] = '{9'h063, 9'h064, 9'h065, 9'h066, 9'h067,
		9'h06c};
	eipc_word_t    rst_v [6] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
	eipc_top #(.VEL_CYCLES(100)) dut_u (.clk(clk), .reset_n(reset_n),
		.enc_a(enc_a), .enc_b(enc_b), .interp_phase(interp_phase),
		.fb_mode(fb_mode), .motor_is_linear(motor_is_linear),
		.index_in(index_in),
		.home_active(home_active), .param_addr(param_addr),
		.param_wr(param_wr), .param_rd(param_rd), .param_wdata(param_wdata),
		.param_rdata(param_rdata), .param_ack(param_ack),
		.param_err(param_err), .axis_position(axis_position),
		.elec_position(elec_position), .phasing_reversed(phasing_reversed),
		.index_spacing_fault(index_spacing_fault), .index_seen(index_seen));
	eipc_enc_model m_u (.clk(clk), .enc_a(enc_a), .enc_b(enc_b),
		.index_in(index_in), .home_active(home_active));
	// Compare and count
	task automatic chk(input eipc_word_t got, input eipc_word_t exp,
		input string what);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask
	// One strobe, answer checked a cycle later
	task automatic xfer(input logic wr, input eipc_addr_t a,
		input eipc_word_t d, input logic err);
		@(posedge clk);
		#1;
		param_addr = a;
		param_wdata = d;
		param_wr = wr;
		param_rd = !wr;
		@(posedge clk);
		#1;
		param_wr = 1'b0;
		param_rd = 1'b0;
		chk({31'h0, param_ack}, 32'h1, "ack");
		chk({31'h0, param_err}, {31'h0, err}, "err");
		rd_data = param_rdata;
	endtask
	task automatic rd(input eipc_addr_t a, input eipc_word_t m,
		input eipc_word_t exp);
		xfer(1'b0, a, 32'h0, 1'b0);
		chk(rd_data & m, exp, "read");
	endtask
	task automatic wr(input eipc_addr_t a, input eipc_word_t d);
		xfer(1'b1, a, d, 1'b0);
	endtask
	task automatic pulse;
		m_u.set_index(1'b1);
		m_u.set_index(1'b0);
	endtask
	task automatic wrap_up;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Watchdog
	initial
	begin
		#20000;
		miscompares++;
		wrap_up();
	end
	// Test sequence
	initial
	begin
		reset_n = 1'b0;
		{param_wr, param_rd, param_addr, param_wdata} = '0;
		interp_phase = 16'h8000;
		motor_is_linear = 1'b0;
		fb_mode = EIPC_FB_QUAD;
		repeat (2) @(posedge clk);
		#1 reset_n = 1'b1;
		foreach (rst_a[i]) rd(rst_a[i], 32'hffffffff, rst_v[i]);
		xfer(1'b0, 9'h0ff, 32'h0, 1'b1);
		chk(rd_data, 32'h0, "unmapped");
		xfer(1'b1, 9'h068, 32'h5, 1'b1);
		wr(9'h063, 32'h1234_0003);
		rd(9'h063, 32'hffffffff, 32'h3);
		wr(9'h064, 32'h8000_000a);
		rd(9'h064, 32'hffffffff, 32'h8000_000a);
		wr(9'h066, 32'h1234_5678);
		rd(9'h066, 32'hffffffff, 32'h1234_5678);
		wr(9'h066, 32'h0);
		wr(9'h06c, 32'hffff);
		rd(9'h06c, 32'hffffffff, 32'h67);
		$display("test registers done");
		wr(9'h06c, 32'h0);
		m_u.move(5);
		chk(axis_position, 32'h5, "forward");
		wr(9'h065, 32'h1);
		repeat (2) @(posedge clk);
		#1;
		chk(axis_position, -32'sd5, "reversed");
		wr(9'h065, 32'h0);
		$display("test direction done");
		wr(9'h06c, 32'h1);
		pulse();
		rd(9'h06d, 32'h9, 32'h1);
		rd(9'h068, 32'hffffffff, 32'h5);
		rd(9'h06d, 32'h9, 32'h0);
		wr(9'h06c, 32'h2);
		m_u.move(3);
		m_u.set_index(1'b1);
		rd(9'h06d, 32'h9, 32'h0);
		m_u.set_index(1'b0);
		rd(9'h06d, 32'h9, 32'h1);
		rd(9'h068, 32'hffffffff, 32'h8);
		$display("test edges done");
		wr(9'h06c, 32'h5);
		pulse();
		m_u.move(2);
		pulse();
		rd(9'h06d, 32'h9, 32'h9);
		rd(9'h068, 32'hffffffff, 32'h8);
		rd(9'h06d, 32'h9, 32'h0);
		wr(9'h06c, 32'h1);
		pulse();
		m_u.move(2);
		pulse();
		rd(9'h06d, 32'h9, 32'h9);
		rd(9'h068, 32'hffffffff, 32'hc);
		$display("test hold done");
		wr(9'h06c, 32'h0);
		pulse();
		rd(9'h06d, 32'h9, 32'h0);
		wr(9'h06c, 32'h3);
		m_u.set_index(1'b1);
		rd(9'h068, 32'hffffffff, 32'hc);
		m_u.set_index(1'b0);
		rd(9'h06d, 32'h9, 32'h1);
		$display("test either edge done");
		wr(9'h06c, 32'h0);
		m_u.set_home(1'b1);
		rd(9'h06d, 32'h10, 32'h10);
		rd(9'h10a, 32'hffffffff, 32'hc);
		m_u.set_home(1'b0);
		rd(9'h06d, 32'h10, 32'h0);
		wr(9'h06c, 32'h20);
		m_u.set_home(1'b1);
		rd(9'h06d, 32'h10, 32'h0);
		m_u.set_home(1'b0);
		rd(9'h06d, 32'h10, 32'h10);
		wr(9'h06c, 32'h60);
		m_u.move(1);
		m_u.set_home(1'b1);
		m_u.set_home(1'b0);
		rd(9'h06d, 32'h90, 32'h90);
		rd(9'h10a, 32'hffffffff, 32'hc);
		$display("test home done");
		motor_is_linear = 1'b1;
		wr(9'h064, 32'ha);
		m_u.move(2);
		chk(elec_position, 32'h6, "elec");
		m_u.move(2);
		chk(elec_position, 32'h2, "elec wrap");
		wr(9'h06c, 32'h1);
		wr(9'h066, 32'h6);
		pulse();
		m_u.move(2);
		pulse();
		chk({31'h0, index_spacing_fault}, 32'h0, "spacing ok");
		m_u.move(3);
		pulse();
		chk({31'h0, index_spacing_fault}, 32'h1, "spacing bad");
		chk({31'h0, index_seen}, 32'h1, "seen");
		wr(9'h066, 32'h0);
		motor_is_linear = 1'b0;
		$display("test linear done");
		// Steady motion of one count per two clocks over whole periods
		fork
			m_u.move(125);
			begin
				repeat (200) @(posedge clk);
				rd(9'h069, 32'hffffffff, 32'h0007_a120);
			end
		join
		repeat (210) @(posedge clk);
		rd(9'h069, 32'hffffffff, 32'h0);
		wr(9'h067, 32'h2);
		interp_phase = 16'hc000;
		fb_mode = EIPC_FB_ANALOG;
		repeat (3) @(posedge clk);
		#1;
		chk(axis_position, 32'h0000_024f, "analog");
		wr(9'h067, 32'h0);
		repeat (2) @(posedge clk);
		#1;
		chk(axis_position, 32'h0000_0093, "four per line");
		$display("test analog done");
		wrap_up();
	end
endmodule
